// file: hdl/ushdp_top.sv
// Shadow receive/transmit data port of a UART with line status and interrupts
//
// Functional notes
// - Sixteen word aliases reach one data port
// - Read returns received byte in low bits
// - Read data valid only while data ready
// - FIFO off: new byte overwrites, flags overrun
// - FIFO on: read returns receive FIFO head
// - Full receive FIFO drops byte, flags overrun
// - Written byte goes to serial or IR output
// - FIFO off: single write clears holding empty
// - FIFO off: extra write replaces pending byte
// - FIFO on: accepts up to depth writes
// - Write to full transmit FIFO is discarded
//
// Behaviour at the bus
//   Every alias of the data port behaves like the primary data address.
//   A read of the data port returns the receive byte one cycle later and zero
//   in every other cycle, so with the FIFOs on a burst of reads yields a burst of bytes.
//   A write of the data port hands one byte to the serialiser side.
//   With the FIFOs off each direction holds one byte; with them on, each
//   direction queues up to FIFO_DEPTH bytes.
//   Toggling the FIFO enable bit discards all queued bytes in both directions;
//   software should change modes only while both directions are idle.
//   Line status overrun clears on a read of line status, but an overrun in that
//   same cycle keeps it set, so no lost byte goes unreported.
//   The slave never stalls the bus: every access completes in one cycle.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ushdp_top
  import ushdp_pkg::*;
#(
  parameter int FIFO_DEPTH = USHDP_FIFO_DEPTH
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  input wire logic TX_READY,
  output logic IR_MODE,
  output logic IRQ
);
  // All state of the block except the two FIFOs in one record
  typedef struct packed {
    logic [31:0] rdata;
    logic fifo_en;
    logic ir_mode;
    logic [7:0] rx_buffer;
    logic rx_full;
    logic [7:0] tx_holding;
    logic tx_full;
    logic overrun;
    logic [USHDP_EV_W-1:0] irq_status;
    logic [USHDP_EV_W-1:0] irq_mask;
  } ushdp_state_t;

  // Registered state and the value it takes at the next enabled edge;
  // one record keeps reset and clock enable uniform across every field
  ushdp_state_t s_q;
  ushdp_state_t s_d;

  // Receive and transmit FIFO handshakes
  logic rxf_push;
  logic rxf_pop;
  logic [7:0] rxf_head;
  logic rxf_full;
  logic rxf_empty;
  logic txf_push;
  logic txf_pop;
  logic [7:0] txf_head;
  logic txf_full;
  logic txf_empty;
  logic fifo_flush;

  // Address decoders for the data port and registers
  logic hit_data;
  logic data_rd;
  logic data_wr;
  logic rx_ready; // Data ready as seen by software
  logic tx_hold_empty; // Holding empty as seen by software
  logic [7:0] rx_head;
  logic tx_accept;

  // Word-aligned address lies in the sixteen-word shadow window.
  // The offset wraps for addresses below the base, which is why the lower
  // bound is tested on its own rather than trusted to the offset compare.
  function automatic logic in_shadow(input logic [31:0] a);
    logic [31:0] off;
    off = a - USHDP_SHADOW_BASE;
    in_shadow = (a[1:0] == 2'h0) && (a >= USHDP_SHADOW_BASE)
      && (off[31:2] < 30'(USHDP_SHADOW_WORDS));
  endfunction

  // The primary address and all sixteen shadow words reach the same logic
  // aliases decoded
  assign hit_data = in_shadow(ADDR) || (ADDR == USHDP_PRIMARY_DATA);
  assign data_rd = RD && hit_data;
  assign data_wr = WR && hit_data;

  // Flags seen through line status
  // In FIFO mode both follow the fill levels, otherwise the single buffers
  assign rx_ready = s_q.fifo_en ? !rxf_empty : s_q.rx_full;
  assign tx_hold_empty = s_q.fifo_en ? txf_empty : !s_q.tx_full;
  assign rx_head = s_q.fifo_en ? rxf_head : s_q.rx_buffer;

  // Changing FIFO mode empties both FIFOs; a rewrite of the same mode keeps them,
  // so software may update the IR mode bit without losing queued bytes
  assign fifo_flush = WR && (ADDR == USHDP_FIFO_CONTROL)
    && (WDATA[USHDP_FIFO_EN_BIT] != s_q.fifo_en);

  // full FIFO ignores push
  // The FIFO refuses a push while full unless its head leaves in the same
  // cycle, so the queued bytes are never overwritten
  assign rxf_push = s_q.fifo_en && RX_VALID;
  assign rxf_pop = s_q.fifo_en && data_rd;
  // Single-buffer writes bypass the FIFO and land in the holding register
  // queue up to depth
  assign txf_push = s_q.fifo_en && data_wr;
  // Serialiser consumes one byte per handshake
  // A stalled serialiser simply leaves TX_VALID up; nothing here times out
  assign tx_accept = TX_VALID && TX_READY;
  assign txf_pop = s_q.fifo_en && tx_accept;

  // Both FIFOs share the mode flush so the two directions change mode together
  // Receive FIFO
  ushdp_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .flush(fifo_flush),
    .push(rxf_push),
    .wdata(RX_BYTE),
    .pop(rxf_pop),
    .head(rxf_head),
    .full(rxf_full),
    .empty(rxf_empty)
  );

  // Transmit FIFO
  ushdp_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .flush(fifo_flush),
    .push(txf_push),
    .wdata(WDATA[7:0]),
    .pop(txf_pop),
    .head(txf_head),
    .full(txf_full),
    .empty(txf_empty)
  );

  // Next-state logic for registers, flags and read data
  always_comb begin
    logic [USHDP_EV_W-1:0] ev;
    logic ovr;
    ev = '0;
    ovr = 1'b0;
    // Hold all state by default; read data falls back to zero every cycle
    s_d = s_q;
    s_d.rdata = 32'h00000000;

    // Receive side, single buffer mode
    // A read and a new byte in one cycle: the new byte stays, with no overrun
    if (!s_q.fifo_en) begin
      if (data_rd) begin
        s_d.rx_full = 1'b0;
      end
      if (RX_VALID) begin
        s_d.rx_buffer = RX_BYTE;
        s_d.rx_full = 1'b1;
        ovr = s_q.rx_full && !data_rd;
      end
    end else if (RX_VALID && rxf_full && !rxf_pop) begin
      // byte lost, overrun
      // A pop in the same cycle frees a slot, so that byte is kept instead
      ovr = 1'h1;
    end

    // Transmit side, single holding mode
    // Hand-off and a new write in one cycle: the new byte becomes pending
    if (!s_q.fifo_en) begin
      if (tx_accept) begin
        s_d.tx_full = 1'b0;
      end
      if (data_wr) begin
        // write clears empty; later write replaces byte
        s_d.tx_holding = WDATA[7:0];
        s_d.tx_full = 1'b1;
      end
    end
    // full FIFO write lost
    // A pop in the same cycle frees a slot, so that write is kept instead
    if (s_q.fifo_en && data_wr && txf_full && !txf_pop) begin
      ev[USHDP_EV_TX_DROP] = 1'b1;
    end

    // Register writes other than the data port
    // Line status is read-only; writes to it fall through to the default
    if (WR) begin
      case (ADDR)
        USHDP_FIFO_CONTROL: begin
          s_d.fifo_en = WDATA[USHDP_FIFO_EN_BIT];
          // The IR mode bit only selects the line; the data path is shared
          s_d.ir_mode = WDATA[USHDP_IR_MODE_BIT];
          // Mode change discards the single buffers too
          if (WDATA[USHDP_FIFO_EN_BIT] != s_q.fifo_en) begin
            s_d.rx_full = 1'b0;
            s_d.tx_full = 1'b0;
          end
        end
        USHDP_IRQ_MASK: s_d.irq_mask = WDATA[USHDP_EV_W-1:0];
        default: begin
        end
      endcase
    end

    // Reads: overrun flag clears on status read, data one cycle later
    // Only one address is decoded per cycle, so RDATA carries a single source
    if (RD) begin
      if (hit_data) begin
        // byte in low bits; zero when not ready
        s_d.rdata = {24'h000000, rx_ready ? rx_head : 8'h00};
      end else begin
        case (ADDR)
          USHDP_FIFO_CONTROL: begin
            s_d.rdata[USHDP_FIFO_EN_BIT] = s_q.fifo_en;
            s_d.rdata[USHDP_IR_MODE_BIT] = s_q.ir_mode;
          end
          USHDP_LINE_STATUS: begin
            s_d.rdata[USHDP_RX_READY_BIT] = rx_ready;
            s_d.rdata[USHDP_OE_BIT] = s_q.overrun;
            s_d.rdata[USHDP_TX_EMPTY_BIT] = tx_hold_empty;
            s_d.overrun = 1'b0;
          end
          USHDP_IRQ_STATUS: s_d.rdata[USHDP_EV_W-1:0] = s_q.irq_status;
          USHDP_IRQ_MASK: s_d.rdata[USHDP_EV_W-1:0] = s_q.irq_mask;
          // Unmapped addresses read zero
          default: begin
          end
        endcase
      end
    end

    // Events: set wins over clear,
    // so an event that lands in the cycle of its clear is still reported;
    // software that clears and re-reads sees it again rather than losing it
    ev[USHDP_EV_OVERRUN] = ovr;
    ev[USHDP_EV_RX_AVAIL] = RX_VALID;
    if (ovr) begin
      s_d.overrun = 1'b1;
    end
    if (WR && ADDR == USHDP_IRQ_STATUS) begin
      s_d.irq_status = s_q.irq_status & ~WDATA[USHDP_EV_W-1:0];
    end
    s_d.irq_status = s_d.irq_status | ev;
  end

  // State register, frozen while the clock enable is low
  // Freezing the FIFOs as well keeps a paused block exactly where it stopped
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q.rdata <= 32'h00000000;
      s_q.fifo_en <= USHDP_CTRL_RST[0];
      s_q.ir_mode <= USHDP_CTRL_RST[1];
      s_q.rx_buffer <= USHDP_DATA_RST;
      s_q.rx_full <= 1'b0;
      s_q.tx_holding <= USHDP_DATA_RST;
      s_q.tx_full <= 1'b0;
      s_q.overrun <= 1'b0;
      s_q.irq_status <= '0;
      s_q.irq_mask <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // byte to serialiser, mode selects serial or IR line
  // TX_VALID is a handshake and may be combinational; the byte comes from flops
  // RDATA is registered, so a read costs exactly one cycle of latency
  assign TX_VALID = s_q.fifo_en ? !txf_empty : s_q.tx_full;
  assign TX_BYTE = s_q.fifo_en ? txf_head : s_q.tx_holding;
  assign IR_MODE = s_q.ir_mode;
  assign RDATA = s_q.rdata;
  // Level interrupt while any unmasked event is pending
  assign IRQ = |(s_q.irq_status & s_q.irq_mask);
endmodule

// file: hdl/ushdp_pkg.sv
// Package: register map, field positions, reset values and sizes of the shadow data port
package ushdp_pkg;
  // Shadow window: sixteen aliased word locations of the data port
  localparam logic [31:0] USHDP_SHADOW_BASE = 32'h50001030;
  localparam int USHDP_SHADOW_WORDS = 16;
  // Documented shadow aliases
  localparam logic [31:0] USHDP_SHADOW_DATA_11 = 32'h5000105C;
  localparam logic [31:0] USHDP_SHADOW_DATA_12 = 32'h50001060;
  // Primary data port and own control/status registers
  localparam logic [31:0] USHDP_PRIMARY_DATA = 32'h50001000;
  localparam logic [31:0] USHDP_FIFO_CONTROL = 32'h50001008;
  localparam logic [31:0] USHDP_LINE_STATUS = 32'h50001014;
  localparam logic [31:0] USHDP_IRQ_STATUS = 32'h50001080;
  localparam logic [31:0] USHDP_IRQ_MASK = 32'h50001084;
  // Field positions
  localparam int USHDP_FIFO_EN_BIT = 0;
  localparam int USHDP_IR_MODE_BIT = 1;
  localparam int USHDP_RX_READY_BIT = 0;
  localparam int USHDP_OE_BIT = 1;
  localparam int USHDP_TX_EMPTY_BIT = 5;
  // Interrupt status bits
  localparam int USHDP_EV_OVERRUN = 0;
  localparam int USHDP_EV_TX_DROP = 1;
  localparam int USHDP_EV_RX_AVAIL = 2;
  localparam int USHDP_EV_W = 3;
  // Reset values
  localparam logic [7:0] USHDP_DATA_RST = 8'h00;
  localparam logic [1:0] USHDP_CTRL_RST = 2'h0;
  // Default FIFO depth
  localparam int USHDP_FIFO_DEPTH = 16;
endpackage

// file: hdl/ushdp_fifo.sv
// Byte FIFO with head output, used for both directions of the data port
`timescale 1ns/1ps
module ushdp_fifo
  import ushdp_pkg::*;
#(
  parameter int DEPTH = USHDP_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] wdata,
  input wire logic pop,
  output logic [7:0] head,
  output logic full,
  output logic empty
);
  // Storage array
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign empty = (cnt_q == '0);
  assign head = mem[rp_q];
  // Push when full is dropped unless the head leaves in the same cycle:
  // queued data is left intact either way
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);

  // Write array; no reset needed on data
  always_ff @(posedge clk) begin
    if (ce && do_push && !flush) begin
      mem[wp_q] <= wdata;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
      end else begin
        if (do_push) begin
          wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
        end
        if (do_pop) begin
          rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
        end
        cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
    end
  end
endmodule

// file: verification/ushdp_top_assertions.sv
// Port-level checks of the shadow data port, bound into the top module
`timescale 1ns/1ps
module ushdp_chk
  import ushdp_pkg::*;
#(parameter int FIFO_DEPTH = USHDP_FIFO_DEPTH) (
  input logic MCLK,
  input logic RESETN,
  input logic CE,
  input logic [31:0] ADDR,
  input logic [31:0] WDATA,
  input logic WR,
  input logic RD,
  input logic [31:0] RDATA,
  input logic RX_VALID,
  input logic [7:0] RX_BYTE,
  input logic TX_VALID,
  input logic [7:0] TX_BYTE,
  input logic TX_READY,
  input logic IR_MODE,
  input logic IRQ
);
  logic fifo_q; // Fifo enable mirror; single-buffer checks hold only with it off
  logic [31:0] off; // Offset into the alias window
  logic is_dat; // Any data port alias or the primary address
  assign off = ADDR - USHDP_SHADOW_BASE;
  assign is_dat = (ADDR == USHDP_PRIMARY_DATA) || (off < 32'h40 && off[1:0] == 2'h0);
  // Follow writes of the fifo enable bit
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN)
      fifo_q <= 1'h0;
    else if (CE && WR && ADDR == USHDP_FIFO_CONTROL)
      fifo_q <= WDATA[USHDP_FIFO_EN_BIT];
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // One byte arrives in single-buffer mode, then a quiet cycle
  sequence s_rx;
    (CE && !fifo_q && RX_VALID && !RD) ##1 (!RD && !RX_VALID);
  endsequence
  a_rdata_idle:
  assert property (!RD |=> RDATA == 32'h0) else $error("read data not idle");
  a_rx_read:
  assert property (s_rx ##1 (RD && is_dat) |=> RDATA == {24'h0, $past(RX_BYTE, 3)})
    else $error("wrong received byte");
  a_dr_set:
  assert property (s_rx ##1 (RD && ADDR == USHDP_LINE_STATUS) |=> RDATA[USHDP_RX_READY_BIT])
    else $error("data ready missing");
  a_overrun_flag:
  assert property (s_rx ##1 s_rx ##1 (RD && ADDR == USHDP_LINE_STATUS) |=> RDATA[1])
    else $error("overrun missing");
  a_tx_load:
  assert property (WR && is_dat && !TX_VALID |=> TX_VALID && TX_BYTE == $past(WDATA[7:0]))
    else $error("byte not offered");
  a_tx_hold:
  assert property (TX_VALID && !TX_READY && !WR |=> TX_VALID && $stable(TX_BYTE))
    else $error("byte not held");
  a_tx_drain:
  assert property (!fifo_q && TX_VALID && TX_READY && !WR |=> !TX_VALID)
    else $error("holding not emptied");
  a_ir_mode:
  assert property (WR && ADDR == USHDP_FIFO_CONTROL |=> IR_MODE == $past(WDATA[1]))
    else $error("path select wrong");
endmodule
bind ushdp_top ushdp_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.MCLK(MCLK), .RESETN(RESETN),
  .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_VALID(RX_VALID),
  .RX_BYTE(RX_BYTE), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY),
  .IR_MODE(IR_MODE), .IRQ(IRQ));

// file: verification/ushdp_link_model.sv
// Link partner: feeds received bytes and takes transmitted ones
`timescale 1ns/1ps
module ushdp_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  logic [7:0] sent[$]; // Bytes taken from the port, in order
  initial begin
    rx_valid = 1'h0;
    rx_byte = 8'hA5;
  end
  // take bytes unless told to stall
  assign tx_ready = rst_n && !stall;
  always @(posedge clk) begin
    if (rst_n && tx_valid && tx_ready)
      sent.push_back(tx_byte);
  end
  // one byte; the lines then show its inverse, never a stale copy
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'h1;
    rx_byte <= b;
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_byte <= ~b;
  endtask
endmodule

// file: verification/uart_shadow_rx_tx_data_port_tb.sv
// Bench: bus tasks, link partner, scripted and random traffic
`timescale 1ns/1ps
module uart_shadow_rx_tx_data_port_tb;
  import ushdp_pkg::*;
  localparam int DEPTH = 4; // Short FIFO keeps fill and drain quick
  logic mclk, resetn, wr, rd, stall, tx_valid, tx_ready, rx_valid, ir_mode, irq, ce;
  logic [31:0] addr, wdata, rdata, d;
  logic [7:0] tx_byte, rx_byte, b;
  logic [7:0] exp_q[$]; // Bytes expected, in order
  int mismatches, samples_checked, seed, i;
  ushdp_top #(.FIFO_DEPTH(DEPTH)) dut_u (.MCLK(mclk), .RESETN(resetn), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_VALID(rx_valid),
    .RX_BYTE(rx_byte), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .TX_READY(tx_ready),
    .IR_MODE(ir_mode), .IRQ(irq));
  ushdp_link_model link_u (.clk(mclk), .rst_n(resetn), .stall(stall), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr32(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'h0;
  endtask
  // Read data stand one cycle only, so take them then
  task automatic rd32(input logic [31:0] a);
    @(posedge mclk);
    rd <= 1'h1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  // Line status: holding empty, overrun, data ready
  task automatic ls(input logic dr, input logic oe, input logic te);
    rd32(USHDP_LINE_STATUS);
    chk(d & 32'h23, {26'h0, te, 3'h0, oe, dr});
  endtask
  function automatic logic [31:0] alias_at(input int k);
    alias_at = USHDP_SHADOW_BASE + 32'(4 * (k % 16));
  endfunction
  // Release the partner, then compare what it took
  task automatic drain();
    @(posedge mclk);
    stall <= 1'h0;
    repeat (DEPTH + 4) @(posedge mclk);
    chk(link_u.sent.size(), exp_q.size());
    while (exp_q.size() > 0)
      chk(link_u.sent.pop_front(), exp_q.pop_front());
    stall <= 1'h1;
  endtask
  task automatic results();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    results();
  end
  initial begin
    {resetn, wr, rd, addr, wdata} = '0;
    stall = 1'h1;
    ce = 1'h1;
    seed = 51344;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'h1;
    #1 chk({tx_valid, ir_mode, irq}, 3'h0);
    rd32(USHDP_SHADOW_DATA_11);
    chk(d, 32'h0);
    // Clock enable low: a byte offered then is not taken
    @(posedge mclk);
    ce <= 1'h0;
    link_u.send(8'h5A);
    ce <= 1'h1;
    ls(0, 0, 1);
    // Single buffer: random bytes through random aliases
    for (i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      link_u.send(b);
      rd32(alias_at($random(seed) & 15));
      chk(d, {24'h0, b});
      ls(0, 0, 1);
    end
    // Overrun, then its interrupt masked, unmasked and cleared
    link_u.send(8'h3C);
    link_u.send(8'hC3);
    ls(1, 1, 1);
    rd32(USHDP_SHADOW_DATA_12);
    chk(d, 32'hC3);
    rd32(USHDP_IRQ_STATUS);
    chk({d[2:0], irq}, 4'hA);
    wr32(USHDP_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'h1);
    wr32(USHDP_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'h0);
    // Second write replaces the pending byte
    wr32(USHDP_PRIMARY_DATA, 32'h11);
    wr32(alias_at(15), 32'h22);
    ls(0, 0, 0);
    exp_q.push_back(8'h22);
    drain();
    ls(0, 0, 1);
    // FIFO mode: overfill receive, drain through aliases
    wr32(USHDP_FIFO_CONTROL, 32'h1);
    for (i = 0; i <= DEPTH; i++) begin
      b = 8'($random(seed));
      link_u.send(b);
      if (i < DEPTH)
        exp_q.push_back(b);
    end
    ls(1, 1, 1);
    for (i = 0; i < DEPTH; i++) begin
      rd32(alias_at(i * 7));
      chk(d, {24'h0, exp_q.pop_front()});
    end
    ls(0, 0, 1);
    // Overfill transmit while the partner stalls
    for (i = 0; i <= DEPTH; i++) begin
      b = 8'($random(seed));
      wr32(alias_at(i), {24'h0, b});
      if (i < DEPTH)
        exp_q.push_back(b);
    end
    rd32(USHDP_IRQ_STATUS);
    chk(d & 32'h2, 32'h2);
    drain();
    wr32(USHDP_FIFO_CONTROL, 32'h2);
    #1 chk(ir_mode, 1'h1);
    rd32(32'h50001200);
    chk(d, 32'h0);
    results();
  end
endmodule
